/* core/ssm_defs.svh */
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH

// ==========================================================
// sizes
`define SSM_NS        32
`define SSM_NT        17
`define SSM_NDO       8
`define SSM_NVAR      8
`define SSM_NCOND     16
`define SSM_LAMP      16
`define SSM_KWW       96

// ==========================================================
// configuration opcodes
`define SSM_OP_NODE   3'h0
`define SSM_OP_SET    3'h1
`define SSM_OP_TRANS  3'h2
`define SSM_OP_DFLT   3'h3
`define SSM_OP_ROOT   3'h4
`define SSM_OP_OWNER  3'h5
`define SSM_OP_TOG    3'h6

// ==========================================================
// field positions in cfg_data
`define SSM_ND_PAR    4:0
`define SSM_ND_HASP   5
`define SSM_ND_CMP    6
`define SSM_ND_INIT   12:8
`define SSM_TR_SRC    4:0
`define SSM_TR_DST    12:8
`define SSM_TR_COND   19:16
`define SSM_TR_NEG    20
`define SSM_TR_VALID  21

// ==========================================================
// reset values and timing
`define SSM_TOG_RST   32'h0000_0001
`define SSM_CLK_NS    5
`define SSM_FLASH_NS  250000000
`define SSM_FLASH_CYC ((`SSM_FLASH_NS) / (`SSM_CLK_NS))

// ==========================================================
// keywords, upper case, right aligned
`define SSM_KW_TRUE   "TRUE"
`define SSM_KW_FALSE  "FALSE"
`define SSM_KW_TOGGLE "TOGGLE"
`define SSM_KW_PASS   "PASSTHROUGH"
`define SSM_KW_FLASH  "FLASH"

`endif

/* core/ssm_pkg.sv */
`default_nettype none

package ssm_pkg;

    // ==========================================================
    // value settings of one target
    typedef enum logic [2:0] {
        SSM_UNDEF  = 3'h0,
        SSM_FALSE  = 3'h1,
        SSM_TRUE   = 3'h2,
        SSM_TOGGLE = 3'h3,
        SSM_PASS   = 3'h4,
        SSM_FLASH  = 3'h5
    } ssm_code_t;

    // ==========================================================
    // engine run state
    typedef enum logic [1:0] {
        SSM_IDLE = 2'b01,
        SSM_RUN  = 2'b10
    } ssm_run_t;

    // ==========================================================
    // state tree node and transition entry
    typedef struct packed {
        logic       has_parent;
        logic [4:0] parent;
        logic       compound;
        logic [4:0] init_child;
    } ssm_node_t;

    typedef struct packed {
        logic       valid;
        logic       neg;
        logic [4:0] src;
        logic [4:0] dst;
        logic [3:0] cond;
    } ssm_trans_t;

endpackage : ssm_pkg

`default_nettype wire

/* core/ssm_kw_if.sv */
`include "ssm_defs.svh"
`default_nettype none

// keyword text out, decoded setting back
interface ssm_kw_if;
    logic [`SSM_KWW-1:0] kw;
    ssm_pkg::ssm_code_t  code;
    modport src (output kw, input code);
    modport dec (input kw, output code);
endinterface : ssm_kw_if

`default_nettype wire

/* core/ssm_kw_decode.sv */
`include "ssm_defs.svh"
`default_nettype none

module ssm_kw_decode (
    // keyword in, setting out
    ssm_kw_if.dec kw_bus
);

    // ==========================================================
    // fold to upper case, then match
    always_comb begin
        logic [`SSM_KWW-1:0] up;
        up = kw_bus.kw;
        for (int i = 0; i < `SSM_KWW / 8; i++) begin
            if (up[i*8 +: 8] >= 8'h61 && up[i*8 +: 8] <= 8'h7A) begin
                up[i*8 +: 8] = up[i*8 +: 8] - 8'h20; // [R18]
            end
        end
        if (up == `SSM_KWW'(`SSM_KW_TRUE)) begin
            kw_bus.code = ssm_pkg::SSM_TRUE;
        end else if (up == `SSM_KWW'(`SSM_KW_FALSE)) begin
            kw_bus.code = ssm_pkg::SSM_FALSE;
        end else if (up == `SSM_KWW'(`SSM_KW_TOGGLE)) begin
            kw_bus.code = ssm_pkg::SSM_TOGGLE;
        end else if (up == `SSM_KWW'(`SSM_KW_PASS)) begin
            kw_bus.code = ssm_pkg::SSM_PASS;
        end else if (up == `SSM_KWW'(`SSM_KW_FLASH)) begin
            kw_bus.code = ssm_pkg::SSM_FLASH;
        end else begin
            kw_bus.code = ssm_pkg::SSM_UNDEF; // unknown word clears
        end
    end

endmodule : ssm_kw_decode

`default_nettype wire

/* core/ssm_solver.sv */
`include "ssm_defs.svh"
`default_nettype none

// Behaviour
// R1 - passthrough channel takes host link value
// R2 - link lost forces passthrough channels false
// R3 - restored link again drives passthrough channels
// R4 - passthrough ignores state logic entirely; out_q still clears passthrough channels while the engine is not running
// R5 - each machine holds up to 32 states
// R6 - start enters initial state, applies outputs
// R7 - any state or compound may be initial
// R8 - compounds nest to any depth
// R9 - entering compound border enters its initial
// R10 - inner states reachable from inside and outside
// R11 - border exit leaves compound from any leaf
// R12 - inner exit leaves the compound state
// R13 - each target has exactly one writing machine
// R14 - innermost active assignment wins
// R15 - true energizes, false not, toggle alternates
// R16 - variables take assigned true or false
// R17 - lamp supports on, off and flash
// R18 - keywords decoded regardless of case
// R19 - undefined target takes its default value
// R20 - compound defaults fill leaf gaps
// R21 - one evaluation step per clock

module ssm_solver #(
    parameter int unsigned FLASH_CYC = `SSM_FLASH_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // program load port
    input  wire logic                 cfg_we,
    input  wire logic [2:0]           cfg_op,
    input  wire logic                 cfg_sm,
    input  wire logic [4:0]           cfg_idx,
    input  wire logic [4:0]           cfg_tgt,
    input  wire logic [31:0]          cfg_data,
    input  wire logic [`SSM_KWW-1:0]  cfg_kw,
    output logic                      cfg_err,
    // execution control
    input  wire logic                 run,
    output logic                      running,
    output logic [9:0]                active_state,
    // pins and host scan link
    input  wire logic [`SSM_NDO-1:0]  din,
    input  wire logic [`SSM_NDO-1:0]  host_do,
    input  wire logic                 link_ok,
    // driven targets
    output logic [`SSM_NDO-1:0]       do_out,
    output logic [`SSM_NVAR-1:0]      var_out,
    output logic                      user_indicator_lamp
);

    // ==========================================================
    // input synchronisers
    logic [`SSM_NDO-1:0]  din_m_q,  din_s_q;
    logic [`SSM_NDO-1:0]  host_m_q, host_s_q;
    logic                 link_m_q, link_s_q;

    // pins and the scan link are asynchronous to clk
    always_ff @(posedge clk) begin
        if (srst) begin
            din_m_q  <= 8'h00;
            din_s_q  <= 8'h00;
            host_m_q <= 8'h00;
            host_s_q <= 8'h00;
            link_m_q <= 1'b0;
            link_s_q <= 1'b0;
        end else begin
            din_m_q  <= din;
            din_s_q  <= din_m_q;
            host_m_q <= host_do;
            host_s_q <= host_m_q;
            link_m_q <= link_ok;
            link_s_q <= link_m_q;
        end
    end

    // ==========================================================
    // keyword decoder
    ssm_kw_if kw_if ();

    assign kw_if.kw = cfg_kw;

    ssm_kw_decode u_dec (
        .kw_bus (kw_if)
    );

    // ==========================================================
    // shared configuration
    ssm_pkg::ssm_code_t   dflt_q  [`SSM_NT];
    logic [`SSM_NT-1:0]   owner_q;
    logic [31:0]          tog_per_q;

    // one owner bit per target makes a second writer impossible
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int t = 0; t < `SSM_NT; t++) begin
                dflt_q[t] <= ssm_pkg::SSM_FALSE;
            end
            owner_q   <= '0;
            tog_per_q <= `SSM_TOG_RST;
        end else if (cfg_we) begin
            if (cfg_op == `SSM_OP_DFLT) begin
                dflt_q[cfg_tgt] <= kw_if.code;              // [R19]
            end
            if (cfg_op == `SSM_OP_OWNER) begin
                owner_q[cfg_tgt] <= cfg_data[0];            // [R13]
            end
            if (cfg_op == `SSM_OP_TOG) begin
                tog_per_q <= cfg_data;                      // [R15]
            end
        end
    end

    // unknown opcode or target flagged for one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_err <= 1'b0;
        end else begin
            cfg_err <= cfg_we && (cfg_op > `SSM_OP_TOG
                       || cfg_tgt >= 5'(`SSM_NT));
        end
    end

    // ==========================================================
    // run control
    ssm_pkg::ssm_run_t run_q;
    logic              start_w;

    assign start_w = (run_q == ssm_pkg::SSM_IDLE) && run;
    assign running = (run_q == ssm_pkg::SSM_RUN);

    always_ff @(posedge clk) begin
        if (srst) begin
            run_q <= ssm_pkg::SSM_IDLE;
        end else begin
            unique case (run_q)
                ssm_pkg::SSM_IDLE: begin
                    if (run) begin
                        run_q <= ssm_pkg::SSM_RUN;
                    end
                end
                ssm_pkg::SSM_RUN: begin
                    if (!run) begin
                        run_q <= ssm_pkg::SSM_IDLE;
                    end
                end
                default: run_q <= ssm_pkg::SSM_IDLE;
            endcase
        end
    end

    // ==========================================================
    // transition conditions: synced inputs and variables
    logic [`SSM_NCOND-1:0] cond_w;
    logic [`SSM_NT-1:0]    out_q;

    assign cond_w = {out_q[15:8], din_s_q};

    // ==========================================================
    // state machine engines
    for (genvar m = 0; m < 2; m++) begin : g_sm
        ssm_pkg::ssm_node_t  node_q  [`SSM_NS];
        ssm_pkg::ssm_trans_t trans_q [`SSM_NS];
        ssm_pkg::ssm_code_t  set_q   [`SSM_NS][`SSM_NT];
        ssm_pkg::ssm_code_t  res_w   [`SSM_NT];
        logic [4:0]          root_q, leaf_q, nxt_w, first_w;
        logic [`SSM_NS-1:0]  act_w;
        logic                fire_w;

        // program tables, 32 states per machine
        always_ff @(posedge clk) begin
            if (srst) begin
                for (int i = 0; i < `SSM_NS; i++) begin
                    node_q[i]  <= '0;
                    trans_q[i] <= '0;
                    for (int t = 0; t < `SSM_NT; t++) begin
                        set_q[i][t] <= ssm_pkg::SSM_UNDEF;
                    end
                end
                root_q <= 5'h00;
            end else if (cfg_we && cfg_sm == 1'(m)) begin
                if (cfg_op == `SSM_OP_NODE) begin
                    node_q[cfg_idx] <= '{                   // [R5] [R8]
                        has_parent: cfg_data[`SSM_ND_HASP],
                        parent:     cfg_data[`SSM_ND_PAR],
                        compound:   cfg_data[`SSM_ND_CMP],
                        init_child: cfg_data[`SSM_ND_INIT]};
                end
                if (cfg_op == `SSM_OP_SET) begin
                    set_q[cfg_idx][cfg_tgt] <= kw_if.code;  // [R18]
                end
                if (cfg_op == `SSM_OP_TRANS) begin
                    trans_q[cfg_idx] <= '{
                        valid: cfg_data[`SSM_TR_VALID],
                        neg:   cfg_data[`SSM_TR_NEG],
                        src:   cfg_data[`SSM_TR_SRC],
                        dst:   cfg_data[`SSM_TR_DST],
                        cond:  cfg_data[`SSM_TR_COND]};
                end
                if (cfg_op == `SSM_OP_ROOT) begin
                    root_q <= cfg_data[4:0];                // [R7]
                end
            end
        end

        // walk leaf to root: mark active set, innermost setting wins
        always_comb begin
            logic [4:0]         cur;
            logic               alive;
            logic [`SSM_NT-1:0] got;
            cur   = leaf_q;
            alive = 1'b1;
            got   = '0;
            act_w = '0;
            for (int t = 0; t < `SSM_NT; t++) begin
                res_w[t] = ssm_pkg::SSM_UNDEF;
            end
            for (int d = 0; d < `SSM_NS; d++) begin
                if (alive) begin
                    act_w[cur] = 1'b1;
                    for (int t = 0; t < `SSM_NT; t++) begin
                        if (!got[t] &&
                            set_q[cur][t] != ssm_pkg::SSM_UNDEF) begin
                            res_w[t] = set_q[cur][t];   // [R14] [R20]
                            got[t]   = 1'b1;
                        end
                    end
                    alive = node_q[cur].has_parent;
                    cur   = node_q[cur].parent;
                end
            end
        end

        // lowest entry index has priority; a source may be any
        // active ancestor, so border exits fire from any leaf
        always_comb begin
            logic [4:0] a;
            logic [4:0] b;
            fire_w = 1'b0;
            a      = 5'h00;
            b      = root_q;
            for (int k = 0; k < `SSM_NS; k++) begin
                if (!fire_w && trans_q[k].valid
                    && act_w[trans_q[k].src]                // [R11] [R12]
                    && (cond_w[trans_q[k].cond] ^ trans_q[k].neg)) begin
                    fire_w = 1'b1;
                    a      = trans_q[k].dst;                // [R10]
                end
            end
            // descend through compound borders to initial leaves
            for (int d = 0; d < `SSM_NS; d++) begin
                if (node_q[a].compound) begin
                    a = node_q[a].init_child;               // [R9]
                end
                if (node_q[b].compound) begin
                    b = node_q[b].init_child;               // [R7]
                end
            end
            nxt_w   = a;
            first_w = b;
        end

        // one step per clock; all machines advance together
        always_ff @(posedge clk) begin
            if (srst) begin
                leaf_q <= 5'h00;
            end else if (start_w) begin
                leaf_q <= first_w;                          // [R6]
            end else if (running && fire_w) begin
                leaf_q <= nxt_w;                            // [R21]
            end
        end
    end

    assign active_state = {g_sm[1].leaf_q, g_sm[0].leaf_q};

    // ==========================================================
    // toggle and flash timebases
    logic [31:0] tog_cnt_q;
    logic [31:0] fl_cnt_q;
    logic        tog_ph_q;
    logic        fl_ph_q;

    // a period of zero behaves as one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            tog_cnt_q <= 32'h0000_0000;
            tog_ph_q  <= 1'b0;
        end else if (tog_cnt_q + 32'h0000_0001 >= tog_per_q) begin
            tog_cnt_q <= 32'h0000_0000;
            tog_ph_q  <= !tog_ph_q;                         // [R15]
        end else begin
            tog_cnt_q <= tog_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fl_cnt_q <= 32'h0000_0000;
            fl_ph_q  <= 1'b0;
        end else if (fl_cnt_q + 32'h0000_0001 >= 32'(FLASH_CYC)) begin
            fl_cnt_q <= 32'h0000_0000;
            fl_ph_q  <= !fl_ph_q;                           // [R17]
        end else begin
            fl_cnt_q <= fl_cnt_q + 32'h0000_0001;
        end
    end

    // ==========================================================
    // per target value resolution
    logic [`SSM_NT-1:0] pass_w;
    logic [`SSM_NT-1:0] val_w;

    // host value only while the link is up; only channels pass
    assign pass_w = {9'h000, host_s_q & {`SSM_NDO{link_s_q}}}; // [R2] [R3]

    for (genvar t = 0; t < `SSM_NT; t++) begin : g_tgt
        ssm_pkg::ssm_code_t code_w;
        ssm_pkg::ssm_code_t eff_w;

        assign code_w = owner_q[t] ? g_sm[1].res_w[t]       // [R13]
                                   : g_sm[0].res_w[t];
        assign eff_w  = (code_w == ssm_pkg::SSM_UNDEF) ? dflt_q[t]
                                                       : code_w; // [R19]

        // passthrough takes pass_w only; out_q still clears it while not running
        always_comb begin
            unique case (eff_w)
                ssm_pkg::SSM_TRUE:   val_w[t] = 1'b1;       // [R15] [R16]
                ssm_pkg::SSM_TOGGLE: val_w[t] = tog_ph_q;
                ssm_pkg::SSM_FLASH:  val_w[t] = fl_ph_q;    // [R17]
                ssm_pkg::SSM_PASS:   val_w[t] = pass_w[t];  // [R1] [R4]
                default:             val_w[t] = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // output register: everything changes on the same edge
    always_ff @(posedge clk) begin
        if (srst || !running) begin
            out_q <= '0;
        end else begin
            out_q <= val_w;                                 // [R21]
        end
    end

    assign do_out              = out_q[`SSM_NDO-1:0];
    assign var_out             = out_q[15:8];
    assign user_indicator_lamp = out_q[`SSM_LAMP];

endmodule : ssm_solver

`default_nettype wire

/* test/ssm_host_model.sv */
`default_nettype none

// ==========================================================
// host controller on the scan link
module ssm_host_model (
    // clock
    input  wire logic       clk,
    // bench commands
    input  wire logic       up,
    input  wire logic [7:0] val,
    // scan link
    output var logic [7:0]  host_do = 8'h00,
    output var logic        link_ok = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    // a dead link holds no last value: show its inverse every cycle
    always @(posedge clk) begin
        link_ok <= up;
        host_do <= up ? val : ~host_do;
    end
endmodule : ssm_host_model

`default_nettype wire

/* test/ssm_solver_checker.sv */
`include "ssm_defs.svh"
`default_nettype none

// ==========================================================
// port checks; bench keeps channels 7:4 host driven
module ssm_solver_checker (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 srst,
    // program load
    input wire logic                 cfg_we,
    input wire logic [2:0]           cfg_op,
    input wire logic [4:0]           cfg_tgt,
    input wire logic                 cfg_err,
    // execution
    input wire logic                 run,
    input wire logic                 running,
    input wire logic [9:0]           active_state,
    // link and targets
    input wire logic [`SSM_NDO-1:0]  host_do,
    input wire logic                 link_ok,
    input wire logic [`SSM_NDO-1:0]  do_out,
    input wire logic [`SSM_NVAR-1:0] var_out,
    input wire logic                 user_indicator_lamp
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    reset_clears_a: assert property (disable iff (1'b0) srst |=>
        do_out == 8'h00 && var_out == 8'h00 && !running && !cfg_err)
        else $error("outputs not cleared by reset");
    bad_write_a: assert property (1'b1 |=> cfg_err == $past(cfg_we
        && !srst && (cfg_op > 3'h6 || cfg_tgt > 5'h10)))
        else $error("error flag does not follow bad write");
    run_start_a: assert property (!running && run |=> running)
        else $error("start not taken");
    run_hold_a: assert property (running && run |=> running)
        else $error("running dropped while run high");
    run_stop_a: assert property (!run |=> !running)
        else $error("running kept after run low");
    stop_quiet_a: assert property (!running |=> do_out == 8'h00
        && var_out == 8'h00 && !user_indicator_lamp)
        else $error("targets driven while stopped");
    leaf_kept_a: assert property (!run && !running
        |=> $stable(active_state))
        else $error("leaf moved while stopped");
    host_pass_a: assert property ((running && link_ok) [*3]
        |=> do_out[7:4] == $past(host_do[7:4], 3))
        else $error("host channel does not follow link");
    host_lost_a: assert property (!link_ok [*3]
        |=> do_out[7:4] == 4'h0)
        else $error("host channel driven with link lost");
endmodule : ssm_solver_checker

bind ssm_solver ssm_solver_checker u_ssm_solver_checker (
    .clk(clk), .srst(srst), .cfg_we(cfg_we), .cfg_op(cfg_op),
    .cfg_tgt(cfg_tgt), .cfg_err(cfg_err), .run(run), .running(running),
    .active_state(active_state), .host_do(host_do), .link_ok(link_ok),
    .do_out(do_out), .var_out(var_out),
    .user_indicator_lamp(user_indicator_lamp)
);

`default_nettype wire

/* test/tb_ssm_solver.sv */
`default_nettype none

// ==========================================================
// bench top
module tb_ssm_solver;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cfg_we = 1'b0;
    logic [2:0]  cfg_op = 3'h0;
    logic        cfg_sm = 1'b0;
    logic [4:0]  cfg_idx = 5'h00;
    logic [4:0]  cfg_tgt = 5'h00;
    logic [31:0] cfg_data = 32'h0;
    logic [95:0] cfg_kw = 96'h0;
    logic        run = 1'b0;
    logic [7:0]  din = 8'h00;
    logic        up = 1'b0;
    logic [7:0]  val = 8'h00;
    logic [7:0]  host_do;
    logic [7:0]  do_out;
    logic [7:0]  var_out;
    logic        link_ok;
    logic        cfg_err;
    logic        running;
    logic        user_indicator_lamp;
    logic [9:0]  active_state;
    int          bad_count = 0;
    int          compares = 0;

    always #2.5 clk = ~clk;

    ssm_solver #(.FLASH_CYC(4)) u_ssm_solver (
        .clk(clk), .srst(srst), .cfg_we(cfg_we), .cfg_op(cfg_op),
        .cfg_sm(cfg_sm), .cfg_idx(cfg_idx), .cfg_tgt(cfg_tgt),
        .cfg_data(cfg_data), .cfg_kw(cfg_kw), .cfg_err(cfg_err),
        .run(run), .running(running), .active_state(active_state),
        .din(din), .host_do(host_do), .link_ok(link_ok),
        .do_out(do_out), .var_out(var_out),
        .user_indicator_lamp(user_indicator_lamp)
    );
    ssm_host_model u_ssm_host_model (
        .clk(clk), .up(up), .val(val), .host_do(host_do), .link_ok(link_ok)
    );

    // ==========================================================
    // helpers
    task automatic finish_test;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, exp, input string msg);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s %0h/%0h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // strobe stays up between back-to-back writes; caller lowers it
    task automatic cfg(input logic [2:0] op, input logic sm,
                       input logic [4:0] idx, tgt, input logic [31:0] d,
                       input logic [95:0] kw);
        cfg_we = 1'b1;
        cfg_op = op;
        cfg_sm = sm;
        cfg_idx = idx;
        cfg_tgt = tgt;
        cfg_data = d;
        cfg_kw = kw;
        @(negedge clk);
    endtask : cfg

    task automatic wait_leaf(input logic [4:0] l);
        int n;
        n = 0;
        while (active_state[4:0] !== l && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20) begin
            bad_count++;
            finish_test();
        end
        @(negedge clk);                       // outputs follow the leaf
    endtask : wait_leaf

    task automatic check_leaf(input logic [4:0] l);
        check({do_out[3], do_out[1:0]},
              l == 0 ? 5 : l == 2 ? 4 : 6, "do");
        check(var_out[1:0], l == 0 ? 3 : 2, "var");
        if (l != 31) begin
            check(user_indicator_lamp, l == 0, "lamp");
        end
    endtask : check_leaf

    // time two successive changes of a toggling target
    task automatic measure(input bit sel, input int exp);
        logic v;
        int   n;
        v = sel ? user_indicator_lamp : do_out[2];
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while ((sel ? user_indicator_lamp : do_out[2]) === v
                   && n < 20) begin
                @(negedge clk);
                n++;
            end
            if (n == 20) begin
                bad_count++;
                finish_test();
            end
            v = ~v;
        end
        check(n, exp, "period");
    endtask : measure

    // ==========================================================
    // scenarios
    task automatic s_errors;
        cfg(3'h7, 1'b0, 5'h00, 5'h00, 32'h0, 96'h0);
        check(cfg_err, 1'b1, "bad op");
        cfg(3'h1, 1'b0, 5'h00, 5'h11, 32'h0, "TRUE");
        cfg_we = 1'b0;
        check(cfg_err, 1'b1, "bad target");
        tick(1);
        check(cfg_err, 1'b0, "error pulse");
    endtask : s_errors

    // tree: 1 holds 4 and 31, 4 holds 2; mixed keyword case
    task automatic s_load;
        cfg(3'h0, 1'b0, 5'd1, 5'd0, 32'h0000_0440, 96'h0);
        cfg(3'h0, 1'b0, 5'd4, 5'd0, 32'h0000_0261, 96'h0);
        cfg(3'h0, 1'b0, 5'd2, 5'd0, 32'h0000_0024, 96'h0);
        cfg(3'h0, 1'b0, 5'd31, 5'd0, 32'h0000_0021, 96'h0);
        cfg(3'h1, 1'b0, 5'd0, 5'd0, 32'h0, "TRUE");
        cfg(3'h1, 1'b0, 5'd0, 5'd2, 32'h0, "ToGgLe");
        cfg(3'h1, 1'b0, 5'd0, 5'd8, 32'h0, "true");
        cfg(3'h1, 1'b0, 5'd0, 5'd16, 32'h0, "True");
        cfg(3'h1, 1'b0, 5'd0, 5'd3, 32'h0, "false");
        cfg(3'h1, 1'b0, 5'd1, 5'd1, 32'h0, "true");
        cfg(3'h1, 1'b0, 5'd1, 5'd16, 32'h0, "fLaSh");
        cfg(3'h1, 1'b0, 5'd2, 5'd1, 32'h0, "False");
        cfg(3'h1, 1'b0, 5'd2, 5'd8, 32'h0, "FALSE");
        cfg(3'h1, 1'b0, 5'd2, 5'd16, 32'h0, "false");
        cfg(3'h1, 1'b1, 5'd0, 5'd3, 32'h0, "TRUE");
        cfg(3'h5, 1'b0, 5'd0, 5'd3, 32'h1, 96'h0);
        cfg(3'h6, 1'b0, 5'd0, 5'd2, 32'h3, 96'h0);
        cfg(3'h3, 1'b0, 5'd0, 5'd9, 32'h0, "TRUE");
        for (int t = 4; t < 8; t++) begin
            cfg(3'h3, 1'b0, 5'd0, 5'(t), 32'h0, "passthrough");
        end
        cfg(3'h2, 1'b0, 5'd0, 5'd0, 32'h0022_0001, 96'h0);
        cfg(3'h2, 1'b0, 5'd1, 5'd0, 32'h0020_0100, 96'h0);
        cfg(3'h2, 1'b0, 5'd2, 5'd0, 32'h0021_1F02, 96'h0);
        cfg(3'h2, 1'b0, 5'd3, 5'd0, 32'h0023_001F, 96'h0);
        cfg(3'h2, 1'b0, 5'd4, 5'd0, 32'h0024_1F00, 96'h0);
        cfg(3'h2, 1'b0, 5'd5, 5'd0, 32'h0039_001F, 96'h0);
        cfg_we = 1'b0;
        check(cfg_err, 1'b0, "good writes");
    endtask : s_load

    task automatic s_walk;
        int         bits [7] = '{0, 1, 3, 4, 2, 0, 2};
        logic [4:0] lf [7] = '{2, 31, 0, 31, 0, 2, 0};
        run = 1'b1;
        tick(1);
        check(running, 1'b1, "start");
        check(active_state, 10'h000, "entry");
        tick(1);
        check_leaf(5'd0);
        for (int i = 0; i < 7; i++) begin
            din = 8'h01 << bits[i];
            wait_leaf(lf[i]);
            check_leaf(lf[i]);
            din = 8'h00;
        end
        measure(1'b0, 3);
        din = 8'h10;
        wait_leaf(5'd31);
        din = 8'h00;
        measure(1'b1, 4);
    endtask : s_walk

    task automatic s_host;
        up = 1'b1;
        val = 8'hA3;
        tick(5);
        check(do_out[7:4], 4'hA, "host value");
        up = 1'b0;
        tick(5);
        check(do_out[7:4], 4'h0, "link lost");
        up = 1'b1;
        val = 8'h5C;
        tick(5);
        check(do_out[7:4], 4'h5, "link back");
    endtask : s_host

    task automatic s_restart;
        run = 1'b0;
        tick(3);
        check(running, 1'b0, "stopped");
        check(do_out, 8'h00, "stopped out");
        check(active_state[4:0], 5'd31, "leaf kept");
        cfg(3'h4, 1'b0, 5'd0, 5'd0, 32'h1, 96'h0);
        cfg_we = 1'b0;
        run = 1'b1;
        wait_leaf(5'd2);
        check_leaf(5'd2);
    endtask : s_restart

    task automatic s_reset;
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        run = 1'b0;
        tick(1);
        check(active_state, 10'h000, "reset leaf");
        check({do_out, var_out}, 16'h0, "reset out");
        check(running, 1'b0, "reset run");
    endtask : s_reset

    // ==========================================================
    // main sequence
    initial begin
        tick(3);
        srst = 1'b0;
        check({do_out, var_out, running}, 17'h0, "idle");
        s_errors();
        s_load();
        s_walk();
        s_host();
        s_restart();
        s_reset();
        finish_test();
    end
endmodule : tb_ssm_solver

`default_nettype wire
